// ---- src/dtb_timer.sv ----
/*
 * Dual timer with baud generator: timers 0 and 1 with four modes, timer 2
 * as a 16-bit autoreload baud generator, and baud ticks for the UART.
 * Assumes synchronous pins, a 25 MHz clock and a plain strobe register port.
 */
// Design decisions made here: the plain strobed port and the register addresses.
//
// What this block does
// [R1] Mode 0 counts the high byte through a divide-by-32 prescaler.
// [R2] Mode 0 count is high byte plus low five bits; upper three ignored.
// [R3] Wrap from all ones to zero sets the timer overflow flag.
// [R4] Counting runs only with run set and qualify off or qualify pin high.
// [R5] Setting the run bit leaves the count registers unchanged.
// [R6] Mode 1 is mode 0 with the full 16-bit count.
// [R7] Mode 2 counts the low byte and reloads it from the high byte.
// [R8] Timer 1 in mode 3 holds its count as if stopped.
// [R9] Timer 0 mode 3 low byte is an 8-bit counter with timer 0 controls.
// [R10] Timer 0 mode 3 high byte counts cycles, uses timer 1 run and flag.
// [R11] Timer 1 stops in its mode 3, restarts out; overflows still feed baud.
// [R12] Timer 1 baud tick is overflow rate times two to doubler over 32.
// [R13] Software usually uses timer 1 autoreload timer mode for baud.
// [R14] Software keeps timer 1 interrupt off while it supplies baud.
// [R15] Timer 2 baud: one bit per 16 timer 2 overflows.
// [R16] Timer 2 in baud mode increments every two core clocks.
// [R17] Transmit or receive select bits put timer 2 in baud mode per direction.
// [R18] Timer 2 baud rate is clock over 32 times 65536 minus reload.
// [R19] Timer operation counts 12-clock machine cycles, counter counts pin edges.
`timescale 1ns/1ps
`default_nettype none
module dtb_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [dtb_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic ext_qualify_pin0,
    input wire logic ext_qualify_pin1,
    input wire logic count_pin0,
    input wire logic count_pin1,
    output logic tx_baud_tick,
    output logic rx_baud_tick,
    output logic irq
);
    import dtb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] timer_mode_reg, timer_ctrl_reg, t2_ctrl_reg, ser_reg;
    logic [7:0] t0_low_byte, t0_high_byte, t1_low_byte, t1_reload_byte;
    logic [7:0] t2_low, t2_high, t2_reload_low, t2_reload_high;
    logic [2:0] irq_stat_reg, irq_mask_reg;
    logic [3:0] mc_cnt_reg;
    logic half_reg;
    logic [1:0] pin_d_reg;
    logic [4:0] pre0_reg, pre1_reg;
    logic [3:0] t2_tx_div_reg, t2_rx_div_reg;
    logic [4:0] t1_baud_div_reg;
    logic [7:0] rdata_reg;

    wire mc_tick = (mc_cnt_reg == MC_LAST); // R19
    wire t2_tick = half_reg; // R16
    wire [1:0] pin_now = {count_pin1, count_pin0};
    wire [1:0] pin_fall = pin_d_reg & ~pin_now; // R19

    wire [3:0] md0 = timer_mode_reg[3:0];
    wire [3:0] md1 = timer_mode_reg[7:4];
    wire t0_split = (md0[1:0] == DTB_MODESPLIT);
    wire t0_run_bit = timer_ctrl_reg[CT_T0RUN];
    wire t1_run_bit = timer_ctrl_reg[CT_T1RUN];

    // Count enable for timer 0 and timer 1, with qualify and source select.
    wire t0_en = t0_run_bit & (~md0[MD_GATE] | ext_qualify_pin0); // R4
    wire t1_en = t1_run_bit & (~md1[MD_GATE] | ext_qualify_pin1)
        & (md1[1:0] != DTB_MODESPLIT); // R8 R11
    wire t0_inc = t0_en & (md0[MD_CT] ? pin_fall[0] : mc_tick); // R19
    // In split mode timer 1 keeps counting for baud, its flag is taken by t0 high.
    wire t1_inc = t1_en & (md1[MD_CT] ? pin_fall[1] : mc_tick);
    wire t0h_split_inc = t0_split & t1_run_bit & mc_tick; // R10

    ////////////////////////////////////////////////////////////////////////
    // Per-timer counting logic for timers 0 and 1.
    logic [7:0] lo_next [2];
    logic [7:0] hi_next [2];
    logic [4:0] pre_next [2];
    logic ovf [2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
            wire [3:0] md = gi == 0 ? md0 : md1;
            wire inc = gi == 0 ? t0_inc : t1_inc;
            wire [7:0] lo = gi == 0 ? t0_low_byte : t1_low_byte;
            wire [7:0] hi = gi == 0 ? t0_high_byte : t1_reload_byte;
            wire [4:0] pre = gi == 0 ? pre0_reg : pre1_reg;
            wire [15:0] full = {hi, lo};
            wire [15:0] full_p1 = full + 16'h0001;
            wire [7:0] lo_p1 = lo + 8'h01;
            wire [7:0] hi_p1 = hi + 8'h01;
            wire pre_wrap = (pre == MODE0_PRESCALE_MAX);
            always_comb begin
                lo_next[gi] = lo;
                hi_next[gi] = hi;
                pre_next[gi] = pre;
                ovf[gi] = 1'b0;
                if (inc) begin
                    case (md[1:0])
                        DTB_MODE13: begin
                            // The prescaler is the low five bits of the low byte.
                            pre_next[gi] = pre + 5'h01; // R1
                            lo_next[gi] = {lo[7:5], lo[4:0] + 5'h01}; // R2
                            if (lo[4:0] == MODE0_PRESCALE_MAX) begin
                                hi_next[gi] = hi_p1; // R1
                                ovf[gi] = (hi == 8'hFF); // R3
                            end
                        end
                        DTB_MODE16: begin
                            lo_next[gi] = full_p1[7:0]; // R6
                            hi_next[gi] = full_p1[15:8];
                            ovf[gi] = (full == 16'hFFFF); // R3
                        end
                        DTB_MODE8AR: begin
                            if (lo == 8'hFF) begin
                                lo_next[gi] = hi; // R7
                                ovf[gi] = 1'b1;
                            end else begin
                                lo_next[gi] = lo_p1;
                            end
                        end
                        default: begin
                            // Split mode for timer 0: low byte alone.
                            lo_next[gi] = lo_p1; // R9
                            ovf[gi] = (gi == 0) && (lo == 8'hFF);
                        end
                    endcase
                end
                if (pre_wrap && !inc) begin
                    pre_next[gi] = pre;
                end
            end
        end
    endgenerate

    // Timer 0 high byte in split mode counts machine cycles on its own.
    wire [7:0] t0h_split_p1 = t0_high_byte + 8'h01;
    wire t0h_ovf = t0h_split_inc & (t0_high_byte == 8'hFF); // R10
    wire t0_ovf = ovf[0];
    wire t1_ovf_raw = ovf[1];
    wire t1_flag_set = t0_split ? t0h_ovf : t1_ovf_raw; // R10

    ////////////////////////////////////////////////////////////////////////
    // Timer 2: 16-bit autoreload, baud mode when either select bit is set.
    wire t2_baud = t2_ctrl_reg[T2_TXSEL] | t2_ctrl_reg[T2_RXSEL]; // R17
    wire t2_inc = t2_ctrl_reg[T2_RUN] & (t2_baud ? t2_tick : mc_tick); // R16
    wire [15:0] t2_full = {t2_high, t2_low};
    wire [15:0] t2_p1 = t2_full + 16'h0001;
    wire t2_ovf = t2_inc & (t2_full == 16'hFFFF);
    wire [15:0] t2_next = t2_ovf ? {t2_reload_high, t2_reload_low} : t2_p1; // R18

    // Timer 1 baud path: divide overflows by 16 with doubler, or by 32.
    wire t1_baud_ovf = t1_ovf_raw;
    wire [4:0] t1_div_p1 = t1_baud_div_reg + 5'h01;
    wire t1_baud_tick = t1_baud_ovf & (ser_reg[SER_DBL] ? (t1_baud_div_reg[3:0] == 4'hF)
        : (t1_baud_div_reg == T1_BAUD_DIV)); // R12
    wire t2_tx_tick = t2_ovf & (t2_tx_div_reg == T2_BAUD_DIV); // R15
    wire t2_rx_tick = t2_ovf & (t2_rx_div_reg == T2_BAUD_DIV); // R15

    ////////////////////////////////////////////////////////////////////////
    // Register write decode.
    wire wr_mode = wr_en & (addr == OFF_MODE);
    wire wr_ctrl = wr_en & (addr == OFF_CTRL);
    wire wr_t0l = wr_en & (addr == OFF_T0L);
    wire wr_t0h = wr_en & (addr == OFF_T0H);
    wire wr_t1l = wr_en & (addr == OFF_T1L);
    wire wr_t1h = wr_en & (addr == OFF_T1H);
    wire wr_t2c = wr_en & (addr == OFF_T2CTRL);
    wire wr_t2l = wr_en & (addr == OFF_T2L);
    wire wr_t2h = wr_en & (addr == OFF_T2H);
    wire wr_capl = wr_en & (addr == OFF_CAPL);
    wire wr_caph = wr_en & (addr == OFF_CAPH);
    wire wr_stat = wr_en & (addr == OFF_IRQ_STAT);
    wire wr_mask = wr_en & (addr == OFF_IRQ_MASK);
    wire wr_ser = wr_en & (addr == OFF_SER);

    // Overflow flags: a set in the same cycle as a software write wins.
    wire [7:0] ctrl_wr_val = wr_ctrl ? wdata : timer_ctrl_reg; // R5
    wire [7:0] ctrl_next = {ctrl_wr_val[7] | t1_flag_set, ctrl_wr_val[6],
        ctrl_wr_val[5] | t0_ovf, ctrl_wr_val[4:0]}; // R3
    wire [2:0] evt = {t2_ovf & ~t2_baud, t1_flag_set, t0_ovf};
    wire [2:0] stat_next = (irq_stat_reg & ~(wr_stat ? wdata[2:0] : 3'h0)) | evt;

    wire [7:0] t0h_next = t0_split ? (t0h_split_inc ? t0h_split_p1 : t0_high_byte)
        : hi_next[0];

    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            OFF_MODE: rd_mux = timer_mode_reg;
            OFF_CTRL: rd_mux = timer_ctrl_reg;
            OFF_T0L: rd_mux = t0_low_byte;
            OFF_T0H: rd_mux = t0_high_byte;
            OFF_T1L: rd_mux = t1_low_byte;
            OFF_T1H: rd_mux = t1_reload_byte;
            OFF_T2CTRL: rd_mux = t2_ctrl_reg;
            OFF_T2L: rd_mux = t2_low;
            OFF_T2H: rd_mux = t2_high;
            OFF_CAPL: rd_mux = t2_reload_low;
            OFF_CAPH: rd_mux = t2_reload_high;
            OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat_reg};
            OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
            OFF_SER: rd_mux = ser_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (rst) begin
            mc_cnt_reg <= 4'h0;
            half_reg <= 1'b0;
            pin_d_reg <= 2'b00;
        end else begin
            mc_cnt_reg <= mc_tick ? 4'h0 : mc_cnt_reg + 4'h1;
            half_reg <= ~half_reg;
            pin_d_reg <= pin_now;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_mode_reg <= RST_BYTE;
            timer_ctrl_reg <= RST_BYTE;
            t2_ctrl_reg <= RST_BYTE;
            ser_reg <= RST_BYTE;
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
        end else begin
            timer_mode_reg <= wr_mode ? wdata : timer_mode_reg;
            timer_ctrl_reg <= ctrl_next;
            t2_ctrl_reg <= wr_t2c ? wdata : t2_ctrl_reg;
            ser_reg <= wr_ser ? wdata : ser_reg;
            irq_stat_reg <= stat_next;
            irq_mask_reg <= wr_mask ? wdata[2:0] : irq_mask_reg;
        end
    end

    // Software writes to a count byte win over the count in that cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            t0_low_byte <= RST_BYTE;
            t0_high_byte <= RST_BYTE;
            t1_low_byte <= RST_BYTE;
            t1_reload_byte <= RST_BYTE;
            pre0_reg <= 5'h00;
            pre1_reg <= 5'h00;
        end else begin
            t0_low_byte <= wr_t0l ? wdata : lo_next[0];
            t0_high_byte <= wr_t0h ? wdata : t0h_next;
            t1_low_byte <= wr_t1l ? wdata : lo_next[1];
            t1_reload_byte <= wr_t1h ? wdata : hi_next[1];
            pre0_reg <= pre_next[0];
            pre1_reg <= pre_next[1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t2_low <= RST_BYTE;
            t2_high <= RST_BYTE;
            t2_reload_low <= RST_BYTE;
            t2_reload_high <= RST_BYTE;
        end else begin
            t2_low <= wr_t2l ? wdata : (t2_inc ? t2_next[7:0] : t2_low);
            t2_high <= wr_t2h ? wdata : (t2_inc ? t2_next[15:8] : t2_high);
            t2_reload_low <= wr_capl ? wdata : t2_reload_low;
            t2_reload_high <= wr_caph ? wdata : t2_reload_high;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t1_baud_div_reg <= 5'h00;
            t2_tx_div_reg <= 4'h0;
            t2_rx_div_reg <= 4'h0;
            tx_baud_tick <= 1'b0;
            rx_baud_tick <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            t1_baud_div_reg <= t1_baud_ovf ? (t1_baud_tick ? 5'h00 : t1_div_p1)
                : t1_baud_div_reg; // R11
            t2_tx_div_reg <= t2_ovf ? t2_tx_div_reg + 4'h1 : t2_tx_div_reg;
            t2_rx_div_reg <= t2_ovf ? t2_rx_div_reg + 4'h1 : t2_rx_div_reg;
            tx_baud_tick <= t2_ctrl_reg[T2_TXSEL] ? t2_tx_tick : t1_baud_tick; // R17
            rx_baud_tick <= t2_ctrl_reg[T2_RXSEL] ? t2_rx_tick : t1_baud_tick; // R17
            rdata_reg <= rd_en ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ---- src/dtb_pkg.sv ----
/*
 * Constants for the dual timer and baud generator: register offsets,
 * field positions, reset values and cycle counts.
 * Assumes a single 25 MHz core clock and a plain strobe register port.
 */
package dtb_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_MODE = 4'h0;
    localparam logic [3:0] OFF_CTRL = 4'h1;
    localparam logic [3:0] OFF_T0L = 4'h2;
    localparam logic [3:0] OFF_T0H = 4'h3;
    localparam logic [3:0] OFF_T1L = 4'h4;
    localparam logic [3:0] OFF_T1H = 4'h5;
    localparam logic [3:0] OFF_T2CTRL = 4'h6;
    localparam logic [3:0] OFF_T2L = 4'h7;
    localparam logic [3:0] OFF_T2H = 4'h8;
    localparam logic [3:0] OFF_CAPL = 4'h9;
    localparam logic [3:0] OFF_CAPH = 4'hA;
    localparam logic [3:0] OFF_IRQ_STAT = 4'hB;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hC;
    localparam logic [3:0] OFF_SER = 4'hD;
    // Mode register nibble fields: [1:0] mode, [2] count source, [3] qualify.
    localparam int MD_CT = 2;
    localparam int MD_GATE = 3;
    // Control register: run bits and overflow flags.
    localparam int CT_T0RUN = 4;
    localparam int CT_T0OVF = 5;
    localparam int CT_T1RUN = 6;
    localparam int CT_T1OVF = 7;
    // Timer 2 control: receive and transmit baud select, run.
    localparam int T2_RXSEL = 4;
    localparam int T2_TXSEL = 5;
    localparam int T2_RUN = 2;
    // Serial control: baud doubler.
    localparam int SER_DBL = 7;
    // Interrupt status bits.
    localparam int IRQ_T0 = 0;
    localparam int IRQ_T1 = 1;
    localparam int IRQ_T2 = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] MODE0_PRESCALE_MAX = 5'h1F;
    localparam int CORE_CLK_HZ = 25000000;
    localparam int MC_CLOCKS = 12;
    localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
    localparam logic [3:0] T2_BAUD_DIV = 4'hF;
    localparam logic [4:0] T1_BAUD_DIV = 5'h1F;
    typedef enum logic [1:0] {
        DTB_MODE13 = 2'b00,
        DTB_MODE16 = 2'b01,
        DTB_MODE8AR = 2'b10,
        DTB_MODESPLIT = 2'b11
    } dtb_mode_t;
endpackage

// ---- dv/dtb_far_side.sv ----
/*
 * Far-side model: external count pulses and the serial port's view of ticks.
 * Assumes the bench clock; pulses are slow enough for a sampled edge detect.
 */
`timescale 1ns/1ps
`default_nettype none
module dtb_far_side (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic tx_baud_tick,
    input wire logic rx_baud_tick,
    output var logic count_pin,
    output var int tx_gap,
    output var int rx_gap
);
    int left = 0;
    int ph = 0;
    int tx_cnt = 0;
    int rx_cnt = 0;
    initial count_pin = 1'b1;
    // Two clocks high and two low per pulse; the pin idles high between bursts.
    always @(posedge clk) begin
        if (go) begin
            left <= n;
            ph <= 0;
        end else if (left > 0) begin
            ph <= (ph + 1) % 4;
            count_pin <= (ph < 2);
            if (ph == 3) left <= left - 1;
        end else begin
            count_pin <= 1'b1;
        end
    end
    // The serial port only sees tick spacing, so that is what is recorded.
    always @(posedge clk) begin
        tx_cnt <= tx_baud_tick ? 1 : tx_cnt + 1;
        rx_cnt <= rx_baud_tick ? 1 : rx_cnt + 1;
        if (tx_baud_tick) tx_gap <= tx_cnt;
        if (rx_baud_tick) rx_gap <= rx_cnt;
    end
endmodule
`default_nettype wire

// ---- dv/dtb_timer_asserts.sv ----
/*
 * Port checker for the dual timer, with shadows of software-written fields.
 * Assumes only the top module's ports are visible; bound below.
 */
`timescale 1ns/1ps
`default_nettype none
module dtb_timer_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [dtb_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic tx_baud_tick,
    input wire logic rx_baud_tick,
    input wire logic irq
);
    import dtb_pkg::*;
    logic [7:0] mask_sh;
    logic [7:0] t2_sh;
    logic [7:0] mode_sh;
    logic t1_run_sh;
    // Timer 0 split mode is left out, though timer 1 still needs its run bit to count there.
    wire logic t1_idle = !t1_run_sh && mode_sh[1:0] != 2'b11;
    wire logic tx_off = t1_idle && !t2_sh[T2_TXSEL];
    wire logic rx_off = t1_idle && !t2_sh[T2_RXSEL];
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_sh <= 8'h00;
            t2_sh <= 8'h00;
            mode_sh <= 8'h00;
            t1_run_sh <= 1'b0;
        end else if (wr_en) begin
            if (addr == OFF_IRQ_MASK) mask_sh <= wdata;
            if (addr == OFF_T2CTRL) t2_sh <= wdata;
            if (addr == OFF_MODE) mode_sh <= wdata;
            if (addr == OFF_CTRL) t1_run_sh <= wdata[CT_T1RUN];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_mode_wr;
        wr_en && addr == OFF_MODE;
    endsequence
    sequence s_mode_rd;
        rd_en && addr == OFF_MODE;
    endsequence
    a_mode_readback:
        assert property (s_mode_wr ##1 !wr_en ##1 s_mode_rd |=> rdata == $past(wdata, 3))
        else $error("mode register read back wrong");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_en && addr > OFF_SER |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_sh == 8'h00 |-> !irq)
        else $error("interrupt high with all sources masked");
    a_tx_gap: assert property (tx_baud_tick |=> !tx_baud_tick [*8])
        else $error("transmit ticks too close");
    a_rx_gap: assert property (rx_baud_tick |=> !rx_baud_tick [*8])
        else $error("receive ticks too close");
    a_tx_quiet: assert property (tx_off && $past(tx_off, 4) |-> !tx_baud_tick)
        else $error("transmit tick with no baud source");
    a_rx_quiet: assert property (rx_off && $past(rx_off, 4) |-> !rx_baud_tick)
        else $error("receive tick with no baud source");
endmodule
bind dtb_timer dtb_timer_asserts u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick), .irq(irq));
`default_nettype wire

// ---- dv/test_dtb_timer.sv ----
/*
 * Self-checking bench for the dual timer: register tasks and scenarios.
 * Assumes the package, design, checker and far-side model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_dtb_timer;
    import dtb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic ext_qualify_pin0 = 1'b0;
    logic go = 1'b0;
    logic [7:0] n = 8'h00;
    logic [7:0] rdata;
    logic pin;
    logic tx_tick;
    logic rx_tick;
    logic irq;
    int tx_gap;
    int rx_gap;
    int bad_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    dtb_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ext_qualify_pin0(ext_qualify_pin0),
        .ext_qualify_pin1(1'b1), .count_pin0(pin), .count_pin1(pin),
        .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick), .irq(irq));
    dtb_far_side far (.clk(clk), .go(go), .n(n), .tx_baud_tick(tx_tick),
        .rx_baud_tick(rx_tick), .count_pin(pin), .tx_gap(tx_gap), .rx_gap(rx_gap));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic cr(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        rd(a, d);
        chk(d & m, e);
    endtask
    task automatic pulses(input logic [7:0] k);
        @(posedge clk);
        go <= 1'b1;
        n <= k;
        @(posedge clk);
        go <= 1'b0;
        repeat (4 * k + 4) @(posedge clk);
    endtask
    task automatic wait_irq(output int c);
        for (c = 1; c <= 100; c++) begin
            @(posedge clk);
            #1;
            if (irq === 1'b1) return;
        end
        bad_count++;
        $display("CHECK FAILED at %0t: no interrupt", $time);
        complete_run();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        int k;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 16; k++) cr(4'(k), 8'h00, 8'hFF);
        wr(4'hE, 8'hFF);
        cr(4'hE, 8'h00, 8'hFF);
        // Same pulses in modes 0 and 1; mode 0 ignores the low byte's top three bits.
        for (k = 0; k < 2; k++) begin
            wr(OFF_MODE, 8'h04 | 8'(k));
            wr(OFF_T0L, 8'hFE);
            wr(OFF_T0H, 8'h12);
            wr(OFF_CTRL, 8'h10);
            pulses(8'd3);
            cr(OFF_T0H, 8'h13, 8'hFF);
            cr(OFF_T0L, 8'h01, (k == 1) ? 8'hFF : 8'h1F);
        end
        wr(OFF_MODE, 8'h0D);
        wr(OFF_T0L, 8'h40);
        wr(OFF_CTRL, 8'h10);
        cr(OFF_T0L, 8'h40, 8'hFF);
        pulses(8'd2);
        cr(OFF_T0L, 8'h40, 8'hFF);
        @(posedge clk);
        ext_qualify_pin0 <= 1'b1;
        pulses(8'd2);
        cr(OFF_T0L, 8'h42, 8'hFF);
        wr(OFF_CTRL, 8'h00);
        pulses(8'd2);
        cr(OFF_T0L, 8'h42, 8'hFF);
        wr(OFF_MODE, 8'h06);
        wr(OFF_T0H, 8'hF0);
        wr(OFF_T0L, 8'hFE);
        wr(OFF_CTRL, 8'h10);
        pulses(8'd3);
        cr(OFF_T0L, 8'hF1, 8'hFF);
        cr(OFF_T0H, 8'hF0, 8'hFF);
        cr(OFF_CTRL, 8'h30, 8'hFF);
        cr(OFF_IRQ_STAT, 8'h01, 8'hFF);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 8'h01);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STAT, 8'h01);
        #1;
        chk({31'h0, irq}, 32'h0);
        // Stop timer 0 first so the loaded count is exact when the run bit is set.
        wr(OFF_CTRL, 8'h00);
        wr(OFF_MODE, 8'h01);
        wr(OFF_T0L, 8'hFE);
        wr(OFF_T0H, 8'hFF);
        wr(OFF_CTRL, 8'h10);
        wait_irq(k);
        chk({31'h0, k > 12 && k < 27}, 32'h1);
        cr(OFF_T0L, 8'h00, 8'hFF);
        cr(OFF_T0H, 8'h00, 8'hFF);
        wr(OFF_IRQ_STAT, 8'h07);
        wr(OFF_IRQ_MASK, 8'h02);
        wr(OFF_MODE, 8'h37);
        cr(OFF_MODE, 8'h37, 8'hFF);
        wr(OFF_T0L, 8'hFE);
        wr(OFF_T0H, 8'hFF);
        wr(OFF_T1L, 8'h55);
        wr(OFF_CTRL, 8'h50);
        pulses(8'd3);
        cr(OFF_T0L, 8'h01, 8'hFF);
        wait_irq(k);
        cr(OFF_IRQ_STAT, 8'h03, 8'hFF);
        cr(OFF_T1L, 8'h55, 8'hFF);
        cr(OFF_CTRL, 8'hF0, 8'hFF);
        wr(OFF_MODE, 8'h07);
        repeat (30) @(posedge clk);
        rd(OFF_T1L, v);
        chk({31'h0, v != 8'h55}, 32'h1);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_MODE, 8'h20);
        wr(OFF_T1H, 8'hFF);
        wr(OFF_T1L, 8'hFF);
        for (k = 0; k < 2; k++) begin
            wr(OFF_SER, 8'(k << 7));
            wr(OFF_CTRL, 8'h40);
            repeat (1300) @(posedge clk);
            chk(tx_gap, (k == 1) ? 192 : 384);
            chk(rx_gap, (k == 1) ? 192 : 384);
        end
        wr(OFF_CTRL, 8'h00);
        wr(OFF_CAPL, 8'hFE);
        wr(OFF_CAPH, 8'hFF);
        wr(OFF_T2L, 8'hFE);
        wr(OFF_T2H, 8'hFF);
        wr(OFF_T2CTRL, 8'h24);
        repeat (300) @(posedge clk);
        chk(tx_gap, 64);
        wr(OFF_T2CTRL, 8'h34);
        repeat (300) @(posedge clk);
        chk(rx_gap, 64);
        complete_run();
    end
endmodule
`default_nettype wire
